//--- design/sync_serial_pkg.sv
// Constants, field layouts and state encodings for the synchronous serial port with RAM burst
package sync_serial_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] SERIAL_CONTROL_ADDR = 16'hfe30;
    localparam logic [15:0] SERIAL_SHIFT_BUFFER_ADDR = 16'hfe31;
    localparam logic [15:0] BAUD_DIVISOR_ADDR = 16'hfe32;
    localparam logic [15:0] BURST_BIT_LENGTH_ADDR = 16'hfe33;
    localparam logic [15:0] BURST_SUSPEND_AND_COUNT_ADDR = 16'hfe37;
    localparam logic [15:0] RAM_BASE_ADDR = 16'h01c0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SERIAL_SHIFT_BUFFER_RESET = 8'h00;
    localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
    localparam logic [7:0] BURST_BIT_LENGTH_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions and counts
    // ------------------------------------------------------------------
    localparam int SUSPEND_BIT = 7;
    localparam int SPARE_HI_BIT = 6;
    localparam int SPARE_LO_BIT = 5;
    localparam int BYTE_COUNT_WIDTH = 5;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;
    localparam logic [8:0] SINGLE_MODE_BITS = 9'h008;
    // Clocks per 2/3 Tcyc unit; half a serial period is (divisor + 1) clocks
    localparam int CLK_PER_BAUD_UNIT = 2;

    typedef struct packed {
        logic ram_bank_select;
        logic ram_write_back_enable;
        logic run_flag;
        logic burst_mode_select;
        logic msb_first_select;
        logic overrun_flag;
        logic transfer_end_flag;
        logic interrupt_enable;
    } serial_control_t;

    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic data_out;
        logic data_io_o;
        logic data_io_oe;
    } serial_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_XCHG = 2'h1,
        ST_SHIFT = 2'h3,
        ST_HOLD = 2'h2
    } serial_state_t;

endpackage : sync_serial_pkg

//--- design/sync_serial_with_ram_burst.sv
// Synchronous serial port with single-byte and RAM burst modes
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module sync_serial_with_ram_burst #(
    parameter int BANK_WORDS = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ext_clock_select,
    input wire logic two_wire_select,
    input wire logic halt_request,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic data_out,
    input wire logic data_io_i,
    output logic data_io_o,
    output logic data_io_oe,
    output logic irq
);

    localparam int PW = $clog2(BANK_WORDS);
    localparam int RAM_WORDS = 2 * BANK_WORDS;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (BANK_WORDS < 2 || BANK_WORDS != (1 << PW) || BANK_WORDS > 128) begin : g_bad_bank
        $error("BANK_WORDS must be a power of two from 2 to 128");
    end
    if (sync_serial_pkg::CLK_PER_BAUD_UNIT != 2) begin : g_bad_unit
        $error("Baud divider assumes two clocks per baud unit");
    end

    typedef struct packed {
        sync_serial_pkg::serial_state_t state;
        sync_serial_pkg::serial_control_t ctl;
        logic [7:0] sr;
        logic [7:0] baud;
        logic [7:0] len;
        logic suspend;
        logic [1:0] spare;
        logic [sync_serial_pkg::BYTE_COUNT_WIDTH-1:0] byte_count;
        logic [PW-1:0] ptr;
        logic [2:0] bit_idx;
        logic [8:0] bits_left;
        logic [7:0] div_cnt;
        logic sck_meta;
        logic sck_sync;
        logic sck_prev;
        logic din_meta;
        logic din_sync;
        sync_serial_pkg::serial_pins_t pins;
        logic [7:0] rdata;
        logic irq;
        logic [RAM_WORDS-1:0][7:0] ram;
    } core_t;

    core_t q;
    core_t next_q;
    logic ext_fall;
    logic ext_rise;
    logic int_toggle;
    logic fall;
    logic rise;
    logic start;
    logic out_bit;
    logic [PW:0] ram_addr;
    logic [15:0] cpu_off;
    logic cpu_ram_hit;

    // ------------------------------------------------------------------
    // Edge detection and address helpers
    // ------------------------------------------------------------------
    always_comb begin
        ext_fall = ext_clock_select && q.sck_prev && !q.sck_sync;
        ext_rise = ext_clock_select && !q.sck_prev && q.sck_sync;
        int_toggle = !ext_clock_select && (q.state == sync_serial_pkg::ST_SHIFT)
            && (q.div_cnt == q.baud);
        fall = ext_clock_select ? ext_fall : (int_toggle && q.pins.sck_out);
        rise = ext_clock_select ? ext_rise : (int_toggle && !q.pins.sck_out);
        out_bit = q.ctl.msb_first_select ? q.sr[7] : q.sr[0];
        ram_addr = {q.ctl.ram_bank_select, q.ptr};
        cpu_off = addr - sync_serial_pkg::RAM_BASE_ADDR;
        cpu_ram_hit = (addr >= sync_serial_pkg::RAM_BASE_ADDR)
            && (cpu_off < 16'(RAM_WORDS));
        start = wr && (addr == sync_serial_pkg::SERIAL_CONTROL_ADDR)
            && wdata[5] && !q.ctl.run_flag && (q.state == sync_serial_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.rdata = 8'h00;
        next_q.sck_meta = sck_in;
        next_q.sck_sync = q.sck_meta;
        next_q.sck_prev = q.sck_sync;
        next_q.din_meta = data_io_i;
        next_q.din_sync = q.din_meta;

        // Register writes
        if (wr) begin
            case (addr)
                sync_serial_pkg::SERIAL_CONTROL_ADDR: begin
                    next_q.ctl = sync_serial_pkg::serial_control_t'(wdata);
                end
                sync_serial_pkg::SERIAL_SHIFT_BUFFER_ADDR: begin
                    next_q.sr = wdata;
                end
                sync_serial_pkg::BAUD_DIVISOR_ADDR: begin
                    next_q.baud = wdata;
                end
                sync_serial_pkg::BURST_BIT_LENGTH_ADDR: begin
                    next_q.len = wdata;
                end
                sync_serial_pkg::BURST_SUSPEND_AND_COUNT_ADDR: begin
                    next_q.suspend = wdata[sync_serial_pkg::SUSPEND_BIT];
                    next_q.spare = {wdata[sync_serial_pkg::SPARE_HI_BIT],
                        wdata[sync_serial_pkg::SPARE_LO_BIT]};
                end
                default: begin
                    if (cpu_ram_hit) begin
                        next_q.ram[cpu_off[PW:0]] = wdata;
                    end
                end
            endcase
        end

        // Register reads, data in the following cycle only
        if (rd) begin
            case (addr)
                sync_serial_pkg::SERIAL_CONTROL_ADDR: begin
                    next_q.rdata = q.ctl;
                end
                sync_serial_pkg::SERIAL_SHIFT_BUFFER_ADDR: begin
                    next_q.rdata = q.sr;
                end
                sync_serial_pkg::BAUD_DIVISOR_ADDR: begin
                    next_q.rdata = q.baud;
                end
                sync_serial_pkg::BURST_BIT_LENGTH_ADDR: begin
                    next_q.rdata = q.len;
                end
                sync_serial_pkg::BURST_SUSPEND_AND_COUNT_ADDR: begin
                    next_q.rdata = {q.suspend, q.spare, q.byte_count};
                end
                default: begin
                    if (cpu_ram_hit) begin
                        next_q.rdata = q.ram[cpu_off[PW:0]];
                    end
                end
            endcase
        end

        // Baud divider, idle level high
        if (q.state == sync_serial_pkg::ST_SHIFT && !ext_clock_select) begin
            if (q.div_cnt == q.baud) begin
                next_q.div_cnt = 8'h00;
                next_q.pins.sck_out = !q.pins.sck_out;
            end else begin
                next_q.div_cnt = q.div_cnt + 8'h01;
            end
        end else begin
            next_q.div_cnt = 8'h00;
            next_q.pins.sck_out = 1'b1;
        end
        next_q.pins.sck_oe = !ext_clock_select;
        next_q.pins.data_io_o = 1'b0;

        // Hardware set wins over a software clear
        if (fall && !q.ctl.run_flag) begin
            next_q.ctl.overrun_flag = 1'b1;
        end
        if (fall && (q.state == sync_serial_pkg::ST_XCHG || q.state == sync_serial_pkg::ST_HOLD)) begin
            next_q.ctl.overrun_flag = 1'b1;
        end

        // Transfer sequencer
        case (q.state)
            sync_serial_pkg::ST_IDLE: begin
                if (start) begin
                    next_q.byte_count = '0;
                    next_q.ptr = '0;
                    next_q.bit_idx = 3'h0;
                    if (wdata[4]) begin
                        next_q.bits_left = {1'b0, q.len} + 9'h001;
                        next_q.state = sync_serial_pkg::ST_XCHG;
                    end else begin
                        next_q.bits_left = sync_serial_pkg::SINGLE_MODE_BITS;
                        next_q.state = sync_serial_pkg::ST_SHIFT;
                    end
                end
            end
            sync_serial_pkg::ST_XCHG: begin
                if (q.ctl.ram_write_back_enable) begin
                    next_q.ram[ram_addr] = q.sr;
                end
                next_q.sr = q.ram[ram_addr];
                next_q.ptr = q.ptr + 1'b1;
                next_q.state = sync_serial_pkg::ST_SHIFT;
            end
            sync_serial_pkg::ST_SHIFT: begin
                if (fall) begin
                    next_q.pins.data_out = out_bit;
                    next_q.pins.data_io_oe = two_wire_select && !out_bit;
                end
                if (rise) begin
                    if (q.ctl.msb_first_select) begin
                        next_q.sr = {q.sr[6:0], q.din_sync};
                    end else begin
                        next_q.sr = {q.din_sync, q.sr[7:1]};
                    end
                    next_q.bit_idx = q.bit_idx + 3'h1;
                    next_q.bits_left = q.bits_left - 9'h001;
                    if (q.ctl.burst_mode_select && q.bit_idx == sync_serial_pkg::LAST_BIT_OF_BYTE) begin
                        next_q.byte_count = q.byte_count + 1'b1;
                    end
                    if (q.bits_left == 9'h001) begin
                        next_q.ctl.run_flag = 1'b0;
                        next_q.ctl.burst_mode_select = 1'b0;
                        next_q.ctl.transfer_end_flag = 1'b1;
                        next_q.state = sync_serial_pkg::ST_IDLE;
                    end else if (q.ctl.burst_mode_select
                        && q.bit_idx == sync_serial_pkg::LAST_BIT_OF_BYTE) begin
                        if (next_q.suspend || halt_request) begin
                            next_q.state = sync_serial_pkg::ST_HOLD;
                        end else begin
                            next_q.state = sync_serial_pkg::ST_XCHG;
                        end
                    end
                end
            end
            sync_serial_pkg::ST_HOLD: begin
                if (!q.suspend && !halt_request) begin
                    next_q.state = sync_serial_pkg::ST_XCHG;
                end
            end
            default: begin
                next_q.state = sync_serial_pkg::ST_IDLE;
            end
        endcase

        // Software clearing the run flag aborts a transfer
        if (!next_q.ctl.run_flag) begin
            next_q.state = sync_serial_pkg::ST_IDLE;
        end
        if (next_q.state == sync_serial_pkg::ST_IDLE) begin
            next_q.pins.data_io_oe = 1'b0;
        end

        next_q.irq = next_q.ctl.interrupt_enable && next_q.ctl.transfer_end_flag;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.state <= sync_serial_pkg::ST_IDLE;
            q.ctl <= sync_serial_pkg::SERIAL_CONTROL_RESET;
            q.sr <= sync_serial_pkg::SERIAL_SHIFT_BUFFER_RESET;
            q.baud <= sync_serial_pkg::BAUD_DIVISOR_RESET;
            q.len <= sync_serial_pkg::BURST_BIT_LENGTH_RESET;
            q.sck_meta <= 1'b1;
            q.sck_sync <= 1'b1;
            q.sck_prev <= 1'b1;
            q.pins.sck_out <= 1'b1;
            q.pins.sck_oe <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    assign rdata = q.rdata;
    assign sck_out = q.pins.sck_out;
    assign sck_oe = q.pins.sck_oe;
    assign data_out = q.pins.data_out;
    assign data_io_o = q.pins.data_io_o;
    assign data_io_oe = q.pins.data_io_oe;
    assign irq = q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_DIVIDER_HOLDS: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && next_q.state == sync_serial_pkg::ST_SHIFT
        && !ext_clock_select && q.div_cnt != q.baud) |=> $stable(sck_out))
        else $error("Serial clock toggled before divisor count reached");
    AST_BANK_WRITE_BACK: assert property (
        (q.state == sync_serial_pkg::ST_XCHG && q.ctl.ram_write_back_enable && !wr)
        |=> q.ram[$past(ram_addr)] == $past(q.sr))
        else $error("Exchange did not store shift register into selected bank");
    AST_LOAD_ONLY: assert property (
        (q.state == sync_serial_pkg::ST_XCHG && !q.ctl.ram_write_back_enable && !wr)
        |=> $stable(q.ram) && q.sr == $past(q.ram[ram_addr]))
        else $error("Load-only exchange changed RAM or missed the load");
    AST_RUN_WHILE_BUSY: assert property (
        (q.state != sync_serial_pkg::ST_IDLE) |-> q.ctl.run_flag)
        else $error("Transfer active with run flag clear");
    AST_END_OF_TRANSFER: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && rise && q.bits_left == 9'h001)
        |=> q.ctl.transfer_end_flag && !q.ctl.run_flag && !q.ctl.burst_mode_select
        && q.state == sync_serial_pkg::ST_IDLE)
        else $error("Last rising edge did not end the transfer");
    AST_OVERRUN_IDLE: assert property (
        (fall && !q.ctl.run_flag) |=> q.ctl.overrun_flag)
        else $error("Falling edge while idle did not flag overrun");
    AST_OVERRUN_XCHG: assert property (
        (fall && (q.state == sync_serial_pkg::ST_XCHG
        || q.state == sync_serial_pkg::ST_HOLD)) |=> q.ctl.overrun_flag)
        else $error("Falling edge during exchange or hold did not flag overrun");
    AST_IRQ_LEVEL: assert property (
        irq == (q.ctl.interrupt_enable && q.ctl.transfer_end_flag))
        else $error("Interrupt request does not follow enable and end flag");
    AST_BURST_LENGTH: assert property (
        (start && wdata[4]) |=> q.bits_left == {1'b0, $past(q.len)} + 9'h001
        && q.state == sync_serial_pkg::ST_XCHG)
        else $error("Burst start loaded the wrong bit count");
    AST_SUSPEND_HOLDS: assert property (
        (q.state == sync_serial_pkg::ST_HOLD && q.suspend && q.ctl.run_flag && !wr)
        |=> q.state == sync_serial_pkg::ST_HOLD)
        else $error("Suspended burst left the hold state");
    AST_ORDER_OUT: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && fall)
        |=> data_out == ($past(q.ctl.msb_first_select) ? $past(q.sr[7]) : $past(q.sr[0])))
        else $error("Wrong bit driven on falling edge");

    COV_SINGLE_DONE: cover property (
        (q.state == sync_serial_pkg::ST_SHIFT && !q.ctl.burst_mode_select)
        ##1 q.ctl.transfer_end_flag);
    COV_BURST_DONE: cover property (
        q.state == sync_serial_pkg::ST_XCHG ##[1:1000] $rose(q.ctl.transfer_end_flag));
    COV_SUSPEND: cover property (q.state == sync_serial_pkg::ST_HOLD ##1
        q.state == sync_serial_pkg::ST_XCHG);
    COV_OVERRUN: cover property ($rose(q.ctl.overrun_flag));
    COV_HALT: cover property (q.state == sync_serial_pkg::ST_HOLD && halt_request);

    // ------------------------------------------------------------------
    // Byte boundary, halt, pin, start and pointer checks
    // ------------------------------------------------------------------
    AST_HALT_HOLDS: assert property (
        (q.state == sync_serial_pkg::ST_HOLD && halt_request && q.ctl.run_flag && !wr)
        |=> q.state == sync_serial_pkg::ST_HOLD)
        else $error("Halted burst left the hold state");
    AST_BYTE_PAUSE: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && rise && q.ctl.burst_mode_select && !wr
        && q.bit_idx == sync_serial_pkg::LAST_BIT_OF_BYTE && q.bits_left != 9'h001
        && (q.suspend || halt_request)) |=> q.state == sync_serial_pkg::ST_HOLD)
        else $error("Burst did not pause at the byte boundary");
    AST_BYTE_COUNT: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && rise && q.ctl.burst_mode_select
        && q.bit_idx == sync_serial_pkg::LAST_BIT_OF_BYTE)
        |=> q.byte_count == $past(q.byte_count) + 5'h01)
        else $error("Byte count did not advance after a full byte");
    AST_TWO_WIRE_OE: assert property (
        (q.state == sync_serial_pkg::ST_SHIFT && fall && !wr)
        |=> data_io_oe == ($past(two_wire_select) && !data_out))
        else $error("Open-drain enable does not follow the bit sent");
    AST_START_CLEARS: assert property (
        start |=> q.byte_count == '0 && q.ptr == '0)
        else $error("Start did not clear byte count and pointer");
    AST_PTR_STEP: assert property (
        (q.state == sync_serial_pkg::ST_XCHG) |=> q.ptr == $past(q.ptr) + 1'b1)
        else $error("Exchange did not step the RAM pointer");

endmodule : sync_serial_with_ram_burst
`default_nettype wire

//--- sim/serial_peer.sv
// Behavioural serial peer on the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
    input wire logic ext_mode,
    input wire logic sck_dut,
    input wire logic mosi,
    output logic sck_peer,
    output logic miso,
    output logic [15:0] rx_bits
);
    logic [16:0] tx_bits;
    logic sck;
    assign sck = ext_mode ? sck_peer : sck_dut;
    assign miso = tx_bits[16];
    initial begin
        sck_peer = 1'b1;
        tx_bits = 17'h00000;
        rx_bits = 16'h0000;
    end
    // Idle bits toggle rather than hold the last value
    always @(negedge sck) begin
        tx_bits <= {tx_bits[15:0], ~tx_bits[16]};
    end
    always @(posedge sck) begin
        rx_bits <= {rx_bits[14:0], mosi};
    end
    task automatic load(input logic [15:0] value);
        tx_bits = {1'b0, value};
        rx_bits = 16'h0000;
    endtask : load
    // Clock runs only within a frame, idle high
    task automatic pulses(input int count);
        // Edges kept off the system clock edge
        #3;
        repeat (count) begin
            #80 sck_peer = 1'b0;
            #80 sck_peer = 1'b1;
        end
    endtask : pulses
endmodule : serial_peer
`default_nettype wire

//--- sim/testbench.sv
// Self-checking testbench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, reset, wr, rd, ext_sel, sck_out, sck_oe, data_out, dio_i, dio_o, dio_oe, irq;
    logic sck_peer, two_wire, halt_req, peer_miso;
    logic [15:0] addr, rx;
    logic [7:0] wdata, rdata, rv;
    int err_total, checked;
    sync_serial_with_ram_burst u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_clock_select(ext_sel), .two_wire_select(two_wire),
        .halt_request(halt_req), .sck_in(sck_peer), .sck_out(sck_out), .sck_oe(sck_oe),
        .data_out(data_out), .data_io_i(dio_i), .data_io_o(dio_o), .data_io_oe(dio_oe),
        .irq(irq));
    serial_peer u_peer (.ext_mode(ext_sel), .sck_dut(sck_out), .mosi(data_out),
        .sck_peer(sck_peer), .miso(peer_miso), .rx_bits(rx));
    // Open-drain data line, pulled low while the port drives it
    assign dio_i = peer_miso & ~dio_oe;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string name);
        rd_reg(a);
        check(name, {8'h00, rv}, {8'h00, exp});
    endtask : rd_chk
    // Poll until the run flag drops
    task automatic wait_idle();
        rd_reg(16'hfe30);
        for (int i = 0; i < 800 && rv[5] !== 1'b0; i++) rd_reg(16'hfe30);
        check("run_flag", {15'h0000, rv[5]}, 16'h0000);
    endtask : wait_idle
    task automatic t_reset();
        rd_chk(16'hfe30, 8'h00, "serial_control");
        rd_chk(16'hfe31, 8'h00, "serial_shift_buffer");
        rd_chk(16'hfe32, 8'h00, "baud_divisor");
        rd_chk(16'hfe33, 8'h00, "burst_bit_length");
        rd_chk(16'hfe37, 8'h00, "burst_suspend_and_count");
        rd_chk(16'hfe34, 8'h00, "unmapped");
        check("idle_pins", {11'h000, sck_out, sck_oe, dio_o, dio_oe, irq}, 16'h0018);
    endtask : t_reset
    task automatic t_single_int();
        wr_reg(16'hfe31, 8'ha5);
        // Divisor 2 gives a half period of three clocks, long enough for the two-stage input synchroniser
        wr_reg(16'hfe32, 8'h02);
        u_peer.load(16'h3c00);
        wr_reg(16'hfe30, 8'h29);
        wait_idle();
        check("peer_rx", rx[7:0], 16'h00a5);
        rd_chk(16'hfe31, 8'h3c, "shift_in");
        rd_chk(16'hfe30, 8'h0b, "control_end");
        check("irq_on", {15'h0000, irq}, 16'h0001);
        wr_reg(16'hfe30, 8'h08);
        repeat (2) @(posedge clk);
        check("irq_off", {15'h0000, irq}, 16'h0000);
    endtask : t_single_int
    task automatic t_single_ext();
        ext_sel <= 1'b1;
        wr_reg(16'hfe31, 8'h01);
        u_peer.load(16'h1e00);
        wr_reg(16'hfe30, 8'h20);
        u_peer.pulses(8);
        wait_idle();
        check("peer_rx_lsb", rx[7:0], 16'h0080);
        rd_chk(16'hfe31, 8'h78, "shift_lsb");
        u_peer.pulses(1);
        repeat (6) @(posedge clk);
        rd_chk(16'hfe30, 8'h06, "overrun");
        wr_reg(16'hfe30, 8'h00);
        rd_chk(16'hfe30, 8'h00, "flags_cleared");
        ext_sel <= 1'b0;
    endtask : t_single_ext
    task automatic t_burst_swap();
        wr_reg(16'h01e0, 8'h11);
        wr_reg(16'h01e1, 8'h22);
        wr_reg(16'hfe31, 8'h5a);
        wr_reg(16'hfe32, 8'h03);
        wr_reg(16'hfe33, 8'h0b);
        u_peer.load(16'hc39f);
        wr_reg(16'hfe30, 8'hf8);
        wait_idle();
        check("peer_rx_burst", {4'h0, rx[11:0]}, 16'h0112);
        rd_chk(16'h01e0, 8'h5a, "ram_swap0");
        rd_chk(16'h01e1, 8'hc3, "ram_swap1");
        rd_chk(16'hfe31, 8'h29, "shift_tail");
        rd_chk(16'hfe30, 8'hca, "control_burst");
        rd_chk(16'hfe37, 8'h01, "byte_count");
    endtask : t_burst_swap
    task automatic t_burst_copy();
        wr_reg(16'h01c0, 8'h01);
        wr_reg(16'hfe31, 8'hff);
        wr_reg(16'hfe33, 8'h00);
        u_peer.load(16'h8000);
        wr_reg(16'hfe30, 8'h30);
        wait_idle();
        check("peer_rx_one", rx, 16'h0001);
        rd_chk(16'h01c0, 8'h01, "ram_kept");
        rd_chk(16'hfe31, 8'h80, "shift_one");
        rd_chk(16'hfe30, 8'h02, "control_one");
    endtask : t_burst_copy
    task automatic t_suspend();
        wr_reg(16'hfe37, 8'hff);
        rd_chk(16'hfe37, 8'he0, "count_read_only");
        wr_reg(16'h01c0, 8'h55);
        wr_reg(16'h01c1, 8'h66);
        wr_reg(16'hfe33, 8'h0f);
        u_peer.load(16'h0000);
        wr_reg(16'hfe30, 8'h38);
        rd_reg(16'hfe37);
        for (int i = 0; i < 400 && rv !== 8'he1; i++) rd_reg(16'hfe37);
        repeat (100) @(posedge clk);
        rd_chk(16'hfe37, 8'he1, "count_held");
        rd_chk(16'hfe30, 8'h38, "run_held");
        wr_reg(16'hfe37, 8'h60);
        wait_idle();
        rd_chk(16'hfe37, 8'h62, "count_final");
        check("peer_rx_resume", rx, 16'h5566);
    endtask : t_suspend
    task automatic t_halt_wire();
        two_wire <= 1'b1;
        halt_req <= 1'b1;
        ext_sel <= 1'b1;
        wr_reg(16'h01c0, 8'h96);
        wr_reg(16'h01c1, 8'h3c);
        wr_reg(16'hfe33, 8'h0f);
        u_peer.load(16'hffff);
        wr_reg(16'hfe30, 8'h38);
        u_peer.pulses(8);
        repeat (8) @(posedge clk);
        check("peer_rx_halt", rx[7:0], 16'h0096);
        check("sck_oe_ext", {15'h0000, sck_oe}, 16'h0000);
        rd_chk(16'hfe37, 8'h61, "halt_count");
        rd_chk(16'hfe31, 8'h96, "two_wire_loop");
        u_peer.pulses(1);
        repeat (6) @(posedge clk);
        rd_chk(16'hfe30, 8'h3c, "overrun_hold");
        halt_req <= 1'b0;
        u_peer.pulses(8);
        wait_idle();
        rd_chk(16'hfe31, 8'h3c, "two_wire_tail");
        rd_chk(16'hfe30, 8'h0e, "control_halt");
        rd_chk(16'hfe37, 8'h62, "halt_count_final");
        wr_reg(16'hfe30, 8'h00);
        two_wire <= 1'b0;
        ext_sel <= 1'b0;
    endtask : t_halt_wire
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        #800000;
        err_total++;
        stop_test();
    end
    initial begin
        err_total = 0;
        checked = 0;
        reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        ext_sel = 1'b0;
        two_wire = 1'b0;
        halt_req = 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_single_int();
        t_single_ext();
        t_burst_swap();
        t_burst_copy();
        t_suspend();
        t_halt_wire();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
